// ===== src/qsrs_pkg.sv
package qsrs_pkg;
	localparam int CLK_NS = 20;
	localparam int SCK_PERIOD_NS = 480;
	localparam int HALF_CYC = SCK_PERIOD_NS / (2 * CLK_NS);
	localparam int SEL_GAP_NS = 50;
	localparam int SEL_GAP_CYC = (SEL_GAP_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] QUAD_MODE_ENTER_CMD = 8'h38;
	localparam logic [7:0] QUAD_MODE_EXIT_CMD = 8'hff;
	localparam logic [7:0] CMD_READ = 8'h03;
	localparam logic [7:0] CMD_FAST_READ = 8'h0b;
	localparam logic [7:0] CMD_DUAL_OUT_READ = 8'h3b;
	localparam logic [7:0] CMD_DUAL_IO_READ = 8'hbb;
	localparam logic [7:0] CMD_QUAD_OUT_READ = 8'h6b;
	localparam logic [7:0] CMD_QUAD_IO_READ = 8'heb;
	localparam logic [7:0] CMD_WRITE = 8'h02;
	localparam logic [7:0] CMD_DUAL_DATA_WRITE = 8'h32;
	localparam logic [7:0] CMD_DUAL_AD_WRITE = 8'hb2;
	localparam logic [7:0] CMD_QUAD_DATA_WRITE = 8'h62;
	localparam logic [7:0] CMD_QUAD_AD_WRITE = 8'he2;
	localparam logic [2:0] W1 = 3'h1;
	localparam logic [2:0] W2 = 3'h2;
	localparam logic [2:0] W4 = 3'h4;
	localparam logic [2:0] DMY_NONE = 3'h0;
	localparam logic [2:0] DMY_ONE = 3'h1;
	localparam logic [2:0] DMY_TWO = 3'h2;
	localparam logic [2:0] DMY_QUAD_MODE = 3'h3;
	localparam logic [2:0] DMY_FOUR = 3'h4;
	localparam logic [5:0] CMD_BITS = 6'h08;
	localparam logic [5:0] ADDR_BITS = 6'h10;
	localparam logic [5:0] WORD_BITS = 6'h20;
	localparam logic [1:0] BURST_DEC = 2'h2;
	localparam logic [1:0] BURST_INC = 2'h1;
	localparam logic [13:0] WORD_STEP = 14'h0004;
	localparam logic [1:0] SI_LANE = 2'h0;
	localparam logic [1:0] SO_LANE = 2'h1;
	localparam logic [3:0] LANES_IDLE = 4'hf;
	localparam logic [5:0] LINK_IDLE = 6'h1f;

	typedef struct packed {
		logic ok;
		logic rd;
		logic [2:0] aw;
		logic [2:0] dummy;
		logic [2:0] dw;
	} qsrs_cmd_s;

	// lane width of address and data, and dummy byte count, for each instruction
	function automatic qsrs_cmd_s qsrs_decode(input logic [7:0] c,
		input logic quad);
		qsrs_cmd_s r;
		r = '0;
		if (quad)
		begin
			case (c)
			CMD_FAST_READ: r = '{1'b1, 1'b1, W4, DMY_QUAD_MODE, W4};
			CMD_WRITE: r = '{1'b1, 1'b0, W4, DMY_NONE, W4};
			default: r = '0;
			endcase
		end
		else
		begin
			case (c)
			CMD_READ: r = '{1'b1, 1'b1, W1, DMY_NONE, W1};
			CMD_FAST_READ: r = '{1'b1, 1'b1, W1, DMY_ONE, W1};
			CMD_DUAL_OUT_READ: r = '{1'b1, 1'b1, W1, DMY_ONE, W2};
			CMD_DUAL_IO_READ: r = '{1'b1, 1'b1, W2, DMY_TWO, W2};
			CMD_QUAD_OUT_READ: r = '{1'b1, 1'b1, W1, DMY_ONE, W4};
			CMD_QUAD_IO_READ: r = '{1'b1, 1'b1, W4, DMY_FOUR, W4};
			CMD_WRITE: r = '{1'b1, 1'b0, W1, DMY_NONE, W1};
			CMD_DUAL_DATA_WRITE: r = '{1'b1, 1'b0, W1, DMY_NONE, W2};
			CMD_DUAL_AD_WRITE: r = '{1'b1, 1'b0, W2, DMY_NONE, W2};
			CMD_QUAD_DATA_WRITE: r = '{1'b1, 1'b0, W1, DMY_NONE, W4};
			CMD_QUAD_AD_WRITE: r = '{1'b1, 1'b0, W4, DMY_NONE, W4};
			default: r = '0;
			endcase
		end
		return r;
	endfunction

	// shift in msb first; single lane uses idx
	function automatic logic [31:0] qsrs_shift_in(input logic [31:0] s,
		input logic [3:0] l, input logic [2:0] w, input logic [1:0] idx);
		case (w)
		W1: return {s[30:0], l[idx]};
		W2: return {s[29:0], l[1:0]};
		default: return {s[27:0], l};
		endcase
	endfunction

	// returns {oe_n, data}; oe_n low marks a driven lane
	function automatic logic [7:0] qsrs_lanes_out(input logic [3:0] v,
		input logic [2:0] w, input logic [1:0] idx);
		case (w)
		W1: return {~(4'h1 << idx), {4{v[3]}}};
		W2: return {4'hc, 2'h0, v[3:2]};
		default: return {4'h0, v};
		endcase
	endfunction

	// data words travel least significant byte first
	function automatic logic [31:0] qsrs_swap(input logic [31:0] d);
		return {d[7:0], d[15:8], d[23:16], d[31:24]};
	endfunction

	// burst step from the two top address bits
	function automatic logic [13:0] qsrs_next_addr(input logic [13:0] a,
		input logic [1:0] m);
		case (m)
		BURST_INC: return a + WORD_STEP;
		BURST_DEC: return a - WORD_STEP;
		default: return a;
		endcase
	endfunction
endpackage

// ===== src/qsrs_link_if.sv
`timescale 1ns/1ns
interface qsrs_link_if;
	logic sck;
	logic serial_select_n;
	logic [3:0] lanes_host;
	logic [3:0] lanes_host_oe_n;
	logic [3:0] lanes_dev;
	logic [3:0] lanes_dev_oe_n;
	logic [3:0] serial_io_lanes;

	// wire level: device first, then host, else pulled high
	assign serial_io_lanes = (~lanes_dev_oe_n & lanes_dev)
		| (lanes_dev_oe_n & ~lanes_host_oe_n & lanes_host)
		| (lanes_dev_oe_n & lanes_host_oe_n);

	modport dev (
		input sck,
		input serial_select_n,
		input serial_io_lanes,
		output lanes_dev,
		output lanes_dev_oe_n
	);

	modport host (
		output sck,
		output serial_select_n,
		output lanes_host,
		output lanes_host_oe_n,
		input serial_io_lanes
	);
endinterface

// ===== src/qsrs_dev_end.sv
`timescale 1ns/1ns
module qsrs_dev_end (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	qsrs_link_if.dev link,
	output logic mem_rd_o,
	output logic mem_wr_o,
	output logic [13:0] mem_addr_o,
	output logic [31:0] mem_wdata_o,
	input wire logic [31:0] mem_rdata_i,
	output logic quad_mode_o
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CMD,
		ST_ADDR,
		ST_DUMMY,
		ST_RDATA,
		ST_WDATA,
		ST_SKIP
	} qsrs_dev_st_e;

	qsrs_dev_st_e st_q;
	logic quad_q;
	logic [5:0] s1_q;
	logic [5:0] s2_q;
	logic [5:0] s3_q;
	logic [5:0] f_q;
	logic [31:0] sh_q;
	logic [5:0] cnt_q;
	logic [2:0] w_q;
	qsrs_pkg::qsrs_cmd_s info_q;
	logic [13:0] addr_q;
	logic [1:0] burst_q;
	logic [13:0] maddr_q;
	logic [31:0] wdata_q;
	logic [31:0] rword_q;
	logic mem_rd_q;
	logic mem_wr_q;
	logic rd_d1_q;
	logic [3:0] dout_q;
	logic [3:0] oe_n_q;

	wire [5:0] raw = {link.sck, link.serial_select_n, link.serial_io_lanes};

	// a bit changes only once the second and third stage agree
	wire [5:0] agree = ~(s2_q ^ s3_q);
	wire [5:0] f_d = (agree & s3_q) | (~agree & f_q);

	// edges of the sampled serial clock
	wire sck_rise = f_d[5] & ~f_q[5];
	wire sck_fall = ~f_d[5] & f_q[5];
	wire sel_n = f_d[4];
	wire [3:0] lanes_in = f_d[3:0];

	// incoming bits and decode of the instruction byte
	wire [31:0] shin = qsrs_pkg::qsrs_shift_in(sh_q, lanes_in, w_q,
		qsrs_pkg::SI_LANE);
	wire [5:0] cnt_nx = cnt_q + {3'h0, w_q};
	wire qsrs_pkg::qsrs_cmd_s dec = qsrs_pkg::qsrs_decode(shin[7:0], quad_q);
	wire [5:0] dummy_bits = {info_q.dummy, 3'h0};
	wire is_enter = shin[7:0] == qsrs_pkg::QUAD_MODE_ENTER_CMD;
	wire is_exit = shin[7:0] == qsrs_pkg::QUAD_MODE_EXIT_CMD;

	// outgoing word: a fresh word is taken at the first bits
	wire [31:0] out_src = (cnt_q == 6'h00)
		? qsrs_pkg::qsrs_swap(rword_q) : sh_q;
	wire [31:0] out_sh = out_src << w_q;
	wire [7:0] out_lanes = qsrs_pkg::qsrs_lanes_out(out_src[31:28], w_q,
		qsrs_pkg::SO_LANE);
	wire [13:0] addr_rx = shin[13:0];
	wire [1:0] burst_rx = shin[15:14];

	// three-stage sampling of clock, select and lanes
	always_ff @(posedge clk_sys_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			s1_q <= qsrs_pkg::LINK_IDLE;
			s2_q <= qsrs_pkg::LINK_IDLE;
			s3_q <= qsrs_pkg::LINK_IDLE;
			f_q <= qsrs_pkg::LINK_IDLE;
		end
		else
		begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q <= f_d;
		end
	end

	// read data is taken the cycle after the strobe
	always_ff @(posedge clk_sys_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			rd_d1_q <= 1'b0;
			rword_q <= 32'h0000_0000;
		end
		else
		begin
			rd_d1_q <= mem_rd_q;
			if (rd_d1_q)
				rword_q <= mem_rdata_i;
		end
	end

	// transfer sequencer, stepped by sampled clock edges
	always_ff @(posedge clk_sys_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			st_q <= ST_IDLE;
			quad_q <= 1'b0;
			sh_q <= 32'h0000_0000;
			cnt_q <= 6'h00;
			w_q <= qsrs_pkg::W1;
			info_q <= '0;
			addr_q <= 14'h0000;
			burst_q <= 2'h0;
			maddr_q <= 14'h0000;
			wdata_q <= 32'h0000_0000;
			mem_rd_q <= 1'b0;
			mem_wr_q <= 1'b0;
			dout_q <= 4'h0;
			oe_n_q <= qsrs_pkg::LANES_IDLE;
		end
		else
		begin
			mem_rd_q <= 1'b0;
			mem_wr_q <= 1'b0;
			// deselect floats lanes, drops any command
			if (sel_n)
			begin
				st_q <= ST_IDLE;
				oe_n_q <= qsrs_pkg::LANES_IDLE;
			end
			else if (st_q == ST_IDLE)
			begin
				// a fresh instruction starts each frame
				st_q <= ST_CMD;
				cnt_q <= 6'h00;
				w_q <= quad_q ? qsrs_pkg::W4 : qsrs_pkg::W1;
			end
			// lanes are sampled on the rising edge
			else if (sck_rise && st_q != ST_RDATA)
			begin
				sh_q <= shin;
				cnt_q <= cnt_nx;
				case (st_q)
				ST_CMD:
				begin
					if (cnt_nx == qsrs_pkg::CMD_BITS)
					begin
						cnt_q <= 6'h00;
						info_q <= dec;
						w_q <= dec.aw;
						if (is_enter && !quad_q)
						begin
							quad_q <= 1'b1;
							st_q <= ST_SKIP;
						end
						else if (is_exit)
						begin
							quad_q <= 1'b0;
							st_q <= ST_SKIP;
						end
						else
							st_q <= dec.ok ? ST_ADDR : ST_SKIP;
					end
				end
				ST_ADDR:
				begin
					if (cnt_nx == qsrs_pkg::ADDR_BITS)
					begin
						cnt_q <= 6'h00;
						addr_q <= addr_rx;
						burst_q <= burst_rx;
						if (!info_q.rd)
						begin
							st_q <= ST_WDATA;
							w_q <= info_q.dw;
						end
						else if (info_q.dummy != qsrs_pkg::DMY_NONE)
							st_q <= ST_DUMMY;
						else
						begin
							// plain read fetches at once
							st_q <= ST_RDATA;
							w_q <= info_q.dw;
							mem_rd_q <= 1'b1;
							maddr_q <= addr_rx;
							addr_q <= qsrs_pkg::qsrs_next_addr(addr_rx,
								burst_rx);
						end
					end
				end
				ST_DUMMY:
				begin
					// dummy bytes before the first fetch
					if (cnt_nx == dummy_bits)
					begin
						cnt_q <= 6'h00;
						st_q <= ST_RDATA;
						w_q <= info_q.dw;
						mem_rd_q <= 1'b1;
						maddr_q <= addr_q;
						addr_q <= qsrs_pkg::qsrs_next_addr(addr_q, burst_q);
					end
				end
				ST_WDATA:
				begin
					// each full word is written, then stepped
					if (cnt_nx == qsrs_pkg::WORD_BITS)
					begin
						cnt_q <= 6'h00;
						mem_wr_q <= 1'b1;
						maddr_q <= addr_q;
						wdata_q <= qsrs_pkg::qsrs_swap(shin);
						addr_q <= qsrs_pkg::qsrs_next_addr(addr_q, burst_q);
					end
				end
				default:
				begin
					st_q <= st_q;
				end
				endcase
			end
			// output bits change on the falling edge
			else if (sck_fall && st_q == ST_RDATA)
			begin
				sh_q <= out_sh;
				{oe_n_q, dout_q} <= out_lanes;
				cnt_q <= (cnt_nx == qsrs_pkg::WORD_BITS) ? 6'h00 : cnt_nx;
				// prefetch the next word while this one shifts
				if (cnt_q == 6'h00)
				begin
					mem_rd_q <= 1'b1;
					maddr_q <= addr_q;
					addr_q <= qsrs_pkg::qsrs_next_addr(addr_q, burst_q);
				end
			end
		end
	end

	assign link.lanes_dev = dout_q;
	assign link.lanes_dev_oe_n = oe_n_q;
	assign mem_rd_o = mem_rd_q;
	assign mem_wr_o = mem_wr_q;
	assign mem_addr_o = maddr_q;
	assign mem_wdata_o = wdata_q;
	assign quad_mode_o = quad_q;
endmodule

// ===== src/qsrs_host_end.sv
`timescale 1ns/1ns
module qsrs_host_end (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	qsrs_link_if.host link,
	input wire logic start_i,
	input wire logic [7:0] cmd_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] words_i,
	input wire logic [31:0] wdata_i,
	output logic wdata_take_o,
	output logic [31:0] rdata_o,
	output logic rdata_valid_o,
	output logic busy_o,
	output logic quad_mode_o
);
	typedef enum logic [2:0] {
		H_IDLE,
		H_CMD,
		H_ADDR,
		H_DUMMY,
		H_DATA,
		H_GAP
	} qsrs_host_st_e;

	qsrs_host_st_e st_q;
	logic quad_q;
	logic sck_q;
	logic sel_n_q;
	logic [3:0] s1_q;
	logic [3:0] s2_q;
	logic [3:0] s3_q;
	logic [3:0] f_q;
	logic [4:0] div_q;
	logic [7:0] cmd_q;
	logic [15:0] addr_q;
	logic [7:0] words_q;
	qsrs_pkg::qsrs_cmd_s info_q;
	logic [31:0] tx_q;
	logic [31:0] rx_q;
	logic [5:0] left_q;
	logic [2:0] w_q;
	logic [3:0] dout_q;
	logic [3:0] oe_n_q;
	logic take_q;
	logic rvalid_q;
	logic [31:0] rdata_q;

	// one fixed rate from the divider, far below 30 MHz
	wire tick = div_q == 5'(qsrs_pkg::HALF_CYC - 1);
	wire [3:0] agree = ~(s2_q ^ s3_q);
	wire [3:0] f_d = (agree & s3_q) | (~agree & f_q);
	wire [2:0] cmd_w = quad_q ? qsrs_pkg::W4 : qsrs_pkg::W1;
	wire [5:0] left_nx = left_q - {3'h0, w_q};
	wire [31:0] tx_sh = tx_q << w_q;
	wire [31:0] wsw = qsrs_pkg::qsrs_swap(wdata_i);
	wire [31:0] rx_in = qsrs_pkg::qsrs_shift_in(rx_q, f_q, w_q,
		qsrs_pkg::SO_LANE);
	wire quiet = st_q == H_DUMMY || (st_q == H_DATA && info_q.rd);
	wire fin = tick && sck_q && left_nx == 6'h00 && st_q != H_GAP;
	wire has_dummy = info_q.rd && info_q.dummy != qsrs_pkg::DMY_NONE;
	wire ctl_cmd = (cmd_q == qsrs_pkg::QUAD_MODE_ENTER_CMD && !quad_q)
		|| cmd_q == qsrs_pkg::QUAD_MODE_EXIT_CMD || !info_q.ok;
	wire go_data = fin && ((st_q == H_ADDR && !has_dummy)
		|| st_q == H_DUMMY || (st_q == H_DATA && words_q > 8'h01));

	// three-stage sampling of the returned lanes
	always_ff @(posedge clk_sys_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			s1_q <= qsrs_pkg::LANES_IDLE;
			s2_q <= qsrs_pkg::LANES_IDLE;
			s3_q <= qsrs_pkg::LANES_IDLE;
			f_q <= qsrs_pkg::LANES_IDLE;
		end
		else
		begin
			s1_q <= link.serial_io_lanes;
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q <= f_d;
		end
	end

	// frame sequencer; clock idles low, data moves at the fall
	always_ff @(posedge clk_sys_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			st_q <= H_IDLE;
			quad_q <= 1'b0;
			sck_q <= 1'b0;
			sel_n_q <= 1'b1;
			div_q <= 5'h00;
			cmd_q <= 8'h00;
			addr_q <= 16'h0000;
			words_q <= 8'h00;
			info_q <= '0;
			tx_q <= 32'h0000_0000;
			rx_q <= 32'h0000_0000;
			left_q <= 6'h00;
			w_q <= qsrs_pkg::W1;
			dout_q <= 4'h0;
			oe_n_q <= qsrs_pkg::LANES_IDLE;
			take_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			take_q <= 1'b0;
			rvalid_q <= 1'b0;
			div_q <= tick ? 5'h00 : div_q + 5'h01;
			case (st_q)
			H_IDLE:
			begin
				div_q <= 5'h00;
				if (start_i)
				begin
					cmd_q <= cmd_i;
					addr_q <= addr_i;
					words_q <= words_i;
					info_q <= qsrs_pkg::qsrs_decode(cmd_i, quad_q);
					w_q <= cmd_w;
					tx_q <= {cmd_i, 24'h00_0000};
					left_q <= qsrs_pkg::CMD_BITS;
					sel_n_q <= 1'b0;
					{oe_n_q, dout_q} <= qsrs_pkg::qsrs_lanes_out(cmd_i[7:4],
						cmd_w, qsrs_pkg::SI_LANE);
					st_q <= H_CMD;
				end
			end
			H_GAP:
			begin
				// idle select spans one half period, beyond 50 ns
				if (tick)
					st_q <= H_IDLE;
			end
			default:
			begin
				if (tick && !sck_q)
				begin
					sck_q <= 1'b1;
					if (st_q == H_DATA && info_q.rd)
						rx_q <= rx_in;
				end
				else if (tick)
				begin
					sck_q <= 1'b0;
					left_q <= left_nx;
					tx_q <= tx_sh;
					if (!quiet)
						{oe_n_q, dout_q} <= qsrs_pkg::qsrs_lanes_out(
							tx_sh[31:28], w_q, qsrs_pkg::SI_LANE);
				end
			end
			endcase
			// phase ends at the falling edge of its last bits
			if (fin)
			begin
				case (st_q)
				H_CMD:
				begin
					// the host tracks the mode it sets
					if (cmd_q == qsrs_pkg::QUAD_MODE_ENTER_CMD && !quad_q)
						quad_q <= 1'b1;
					else if (cmd_q == qsrs_pkg::QUAD_MODE_EXIT_CMD)
						quad_q <= 1'b0;
				end
				H_DATA:
				begin
					if (info_q.rd)
					begin
						rdata_q <= qsrs_pkg::qsrs_swap(rx_q);
						rvalid_q <= 1'b1;
					end
					words_q <= words_q - 8'h01;
				end
				default:
				begin
					words_q <= words_q;
				end
				endcase
				if (st_q == H_CMD && !ctl_cmd)
				begin
					// address on its own width, MSB first
					st_q <= H_ADDR;
					tx_q <= {addr_q, 16'h0000};
					left_q <= qsrs_pkg::ADDR_BITS;
					w_q <= info_q.aw;
					{oe_n_q, dout_q} <= qsrs_pkg::qsrs_lanes_out(
						addr_q[15:12], info_q.aw, qsrs_pkg::SI_LANE);
				end
				else if (st_q == H_ADDR && has_dummy)
				begin
					// lanes released through the dummy bytes
					st_q <= H_DUMMY;
					left_q <= {info_q.dummy, 3'h0};
					oe_n_q <= qsrs_pkg::LANES_IDLE;
				end
				else if (!go_data)
				begin
					st_q <= H_GAP;
					sel_n_q <= 1'b1;
					oe_n_q <= qsrs_pkg::LANES_IDLE;
				end
			end
			// next data word on the data width
			if (go_data)
			begin
				st_q <= H_DATA;
				left_q <= qsrs_pkg::WORD_BITS;
				w_q <= info_q.dw;
				if (info_q.rd)
					oe_n_q <= qsrs_pkg::LANES_IDLE;
				else
				begin
					tx_q <= wsw;
					take_q <= 1'b1;
					{oe_n_q, dout_q} <= qsrs_pkg::qsrs_lanes_out(wsw[31:28],
						info_q.dw, qsrs_pkg::SI_LANE);
				end
			end
		end
	end

	assign link.sck = sck_q;
	assign link.serial_select_n = sel_n_q;
	assign link.lanes_host = dout_q;
	assign link.lanes_host_oe_n = oe_n_q;
	assign wdata_take_o = take_q;
	assign rdata_o = rdata_q;
	assign rdata_valid_o = rvalid_q;
	assign busy_o = st_q != H_IDLE;
	assign quad_mode_o = quad_q;
endmodule

// ===== bench/qsrs_link_properties.sv
`timescale 1ns/1ns
module qsrs_link_properties (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic sck,
	input wire logic serial_select_n,
	input wire logic [3:0] lanes_host,
	input wire logic [3:0] lanes_host_oe_n,
	input wire logic [3:0] lanes_dev,
	input wire logic [3:0] lanes_dev_oe_n
);
	// every link wire is sampled by the one system clock
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (sys_rst_i);

	// deselect reaches the device late, so allow its sync delay
	a_float_when_idle: assert property (
		serial_select_n [*8] |-> lanes_dev_oe_n == 4'hf)
		else $error("device drives lanes while deselected");
	a_sck_rests_low: assert property (
		serial_select_n [*4] |-> !sck)
		else $error("serial clock moves outside a frame");
	a_setup_before_rise: assert property (
		$fell(serial_select_n) |-> !sck [*8])
		else $error("first clock rise too soon after select");
	a_select_gap: assert property (
		$rose(serial_select_n) |-> serial_select_n [*3])
		else $error("select high for less than 50 ns");
	a_cmd_on_lane0: assert property (
		$fell(serial_select_n) |-> ##[0:1] !lanes_host_oe_n[0])
		else $error("instruction lane not driven");
	// a turnaround slip would show as both ends on one lane
	a_no_contention: assert property (
		(lanes_dev_oe_n | lanes_host_oe_n) == 4'hf)
		else $error("both ends drive one lane");
	a_dev_change_low: assert property (
		!serial_select_n && $changed(lanes_dev & ~lanes_dev_oe_n) |-> !sck)
		else $error("device output changes while clock high");
	a_host_hold_high: assert property (
		sck && $past(sck) |-> $stable(lanes_host))
		else $error("host data moves while clock high");

	// read shapes: one, two and four lanes from the device
	c_single_read: cover property (lanes_dev_oe_n == 4'hd);
	c_dual_read: cover property (lanes_dev_oe_n == 4'hc);
	c_quad_read: cover property (lanes_dev_oe_n == 4'h0);
endmodule

// ===== bench/quad_serial_register_slave_tb_top.sv
`timescale 1ns/1ns
module quad_serial_register_slave_tb_top;
	logic clk_sys_i, sys_rst_i, start_i;
	logic [7:0] cmd_i, words_i, cmd_seen;
	logic [15:0] addr_i, cur_addr;
	logic [31:0] wdata_i, mem_rdata_i, rdata_o, mem_wdata_o, dev2_wdata, d2;
	logic wdata_take_o, rdata_valid_o, busy_o, host_quad, dev_quad;
	logic mem_rd_o, mem_wr_o, dev2_wr;
	logic [13:0] mem_addr_o, dev2_addr, a2;
	logic [31:0] mem [0:4095];
	logic [31:0] wq [0:7];
	logic [7:0] wr_tab [0:5];
	logic [7:0] rd_tab [0:5];
	logic [31:0] rs = 32'heb002073;
	int err_total, n_checks, wcnt, rcnt, rdn, widx, bitn, n2_wr;

	qsrs_link_if link ();
	qsrs_link_if link2 ();
	qsrs_dev_end qsrs_dev_end_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.link(link.dev), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
		.mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
		.mem_rdata_i(mem_rdata_i), .quad_mode_o(dev_quad));
	qsrs_host_end qsrs_host_end_i (.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i), .link(link.host), .start_i(start_i),
		.cmd_i(cmd_i), .addr_i(addr_i), .words_i(words_i), .wdata_i(wdata_i),
		.wdata_take_o(wdata_take_o), .rdata_o(rdata_o),
		.rdata_valid_o(rdata_valid_o), .busy_o(busy_o),
		.quad_mode_o(host_quad));
	// second device faces a bench driver that cuts frames short
	qsrs_dev_end qsrs_dev_end_fault_i (.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i), .link(link2.dev), .mem_rd_o(),
		.mem_wr_o(dev2_wr), .mem_addr_o(dev2_addr), .mem_wdata_o(dev2_wdata),
		.mem_rdata_i(32'h0), .quad_mode_o());
	qsrs_link_properties qsrs_link_properties_i (.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i), .sck(link.sck),
		.serial_select_n(link.serial_select_n), .lanes_host(link.lanes_host),
		.lanes_host_oe_n(link.lanes_host_oe_n), .lanes_dev(link.lanes_dev),
		.lanes_dev_oe_n(link.lanes_dev_oe_n));

	initial
	begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction

	// byte address of word k of a burst
	function automatic logic [13:0] word_addr(input logic [15:0] a,
		input int k);
		logic [13:0] s;
		s = 14'(4 * k);
		case (a[15:14])
		2'h1: return a[13:0] + s;
		2'h2: return a[13:0] - s;
		default: return a[13:0];
		endcase
	endfunction

	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic finish_test();
		if (err_total == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// memory answers every cycle; only the word after a strobe counts
	always @(posedge clk_sys_i)
	begin
		mem_rdata_i <= mem[mem_addr_o[13:2]];
		if (wdata_take_o === 1'b1)
		begin
			widx <= widx + 1;
			wdata_i <= wq[widx + 1];
		end
	end

	// strobes seen before this edge's updates, so values are settled
	always @(posedge clk_sys_i)
	begin
		if (mem_wr_o === 1'b1)
		begin
			check("mem_addr", mem_addr_o, word_addr(cur_addr, wcnt));
			check("mem_wdata", mem_wdata_o, wq[wcnt]);
			mem[word_addr(cur_addr, wcnt) >> 2] = wq[wcnt];
			wcnt++;
		end
		if (rdata_valid_o === 1'b1)
		begin
			check("rdata", rdata_o, mem[word_addr(cur_addr, rcnt) >> 2]);
			rcnt++;
		end
		// fetches run one word ahead, so word k is read at strobe k
		if (mem_rd_o === 1'b1)
		begin
			check("rd_addr", mem_addr_o, word_addr(cur_addr, rdn));
			rdn++;
		end
		if (dev2_wr === 1'b1)
		begin
			n2_wr++;
			a2 = dev2_addr;
			d2 = dev2_wdata;
		end
	end

	// instruction bits as they appear on lane 0 of the wire
	always @(posedge link.sck)
	begin
		if (bitn < 8)
			cmd_seen <= {cmd_seen[6:0], link.serial_io_lanes[0]};
		bitn <= bitn + 1;
	end
	always @(posedge link.serial_select_n)
		bitn <= 0;

	task automatic run_frame(input logic [7:0] c, input logic [15:0] a,
		input logic [7:0] n);
		int k;
		logic q;
		q = host_quad;
		cur_addr = a;
		wcnt = 0;
		rcnt = 0;
		rdn = 0;
		@(posedge clk_sys_i);
		cmd_i <= c;
		addr_i <= a;
		words_i <= n;
		wdata_i <= wq[0];
		widx <= 0;
		start_i <= 1'b1;
		@(posedge clk_sys_i);
		start_i <= 1'b0;
		@(posedge clk_sys_i);
		for (k = 0; k < 30000 && busy_o !== 1'b0; k++)
			@(posedge clk_sys_i);
		if (k >= 30000)
		begin
			err_total++;
			finish_test();
		end
		if (q !== 1'b1)
			check("cmd_wire", {24'h0, cmd_seen}, {24'h0, c});
		check("idle_lanes", {28'h0, link.serial_io_lanes}, 32'hf);
	endtask

	task automatic wr_rd(input logic [7:0] cw, input logic [7:0] cr,
		input logic [15:0] a, input logic [7:0] n);
		int k;
		for (k = 0; k < 8; k++)
			wq[k] = rnd();
		run_frame(cw, a, n);
		check("writes", wcnt, (n == 0) ? 1 : n);
		run_frame(cr, a, n);
		check("reads", rcnt, (n == 0) ? 1 : n);
	endtask

	// bench-made frame: lane 0 only, 160 ns serial clock
	task automatic bb_frame(input logic [55:0] v, input int n);
		int i;
		link2.serial_select_n <= 1'b0;
		link2.lanes_host_oe_n <= 4'he;
		for (i = 55; i > 55 - n; i--)
		begin
			link2.lanes_host <= {3'h0, v[i]};
			repeat (4) @(posedge clk_sys_i);
			link2.sck <= 1'b1;
			repeat (4) @(posedge clk_sys_i);
			link2.sck <= 1'b0;
		end
		repeat (8) @(posedge clk_sys_i);
		link2.serial_select_n <= 1'b1;
		link2.lanes_host_oe_n <= 4'hf;
		link2.lanes_host <= ~link2.lanes_host;
		repeat (8) @(posedge clk_sys_i);
	endtask

	initial
	begin
		int i;
		logic [15:0] a;
		sys_rst_i = 1'b1;
		start_i = 1'b0;
		cmd_i = 8'h00;
		addr_i = 16'h0000;
		words_i = 8'h00;
		wdata_i = 32'h0;
		mem_rdata_i = 32'h0;
		link2.sck = 1'b0;
		link2.serial_select_n = 1'b1;
		link2.lanes_host = 4'h0;
		link2.lanes_host_oe_n = 4'hf;
		err_total = 0;
		n_checks = 0;
		bitn = 0;
		n2_wr = 0;
		widx = 0;
		wr_tab = '{qsrs_pkg::CMD_WRITE, qsrs_pkg::CMD_DUAL_DATA_WRITE,
			qsrs_pkg::CMD_DUAL_AD_WRITE, qsrs_pkg::CMD_QUAD_DATA_WRITE,
			qsrs_pkg::CMD_QUAD_AD_WRITE, qsrs_pkg::CMD_WRITE};
		rd_tab = '{qsrs_pkg::CMD_READ, qsrs_pkg::CMD_FAST_READ,
			qsrs_pkg::CMD_DUAL_OUT_READ, qsrs_pkg::CMD_DUAL_IO_READ,
			qsrs_pkg::CMD_QUAD_OUT_READ, qsrs_pkg::CMD_QUAD_IO_READ};
		for (i = 0; i < 4096; i++)
			mem[i] = rnd();
		repeat (16) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_sys_i);
		check("busy_rst", {31'h0, busy_o}, 32'h0);
		check("quad_rst", {31'h0, dev_quad}, 32'h0);
		// every serial command; burst modes cycle 00..11, words 0 once
		for (i = 0; i < 6; i++)
		begin
			a = 16'(rnd());
			a[15:14] = i[1:0];
			a[1:0] = 2'h0;
			if (i == 0)
				a = 16'h8000; // decrement wraps below zero
			wr_rd(wr_tab[i], rd_tab[i], a,
				(i == 5) ? 8'h00 : 8'(1 + rnd() % 3));
		end
		run_frame(qsrs_pkg::QUAD_MODE_ENTER_CMD, 16'h0, 8'h01);
		check("dev_quad", {31'h0, dev_quad}, 32'h1);
		check("host_quad", {31'h0, host_quad}, 32'h1);
		wr_rd(qsrs_pkg::CMD_WRITE, qsrs_pkg::CMD_FAST_READ,
			{2'h1, 14'(rnd()) & 14'h3ffc}, 8'h03);
		run_frame(qsrs_pkg::QUAD_MODE_ENTER_CMD, 16'h0, 8'h01);
		check("quad_again", {31'h0, dev_quad}, 32'h1);
		run_frame(qsrs_pkg::QUAD_MODE_EXIT_CMD, 16'h0, 8'h01);
		check("dev_serial", {31'h0, dev_quad}, 32'h0);
		check("host_serial", {31'h0, host_quad}, 32'h0);
		// reset in mid-run must drop both ends back to serial mode
		run_frame(qsrs_pkg::QUAD_MODE_ENTER_CMD, 16'h0, 8'h01);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_sys_i);
		check("quad_reset", {30'h0, dev_quad, host_quad}, 32'h0);
		// cut a write mid-address, then one clean word to 0244h
		@(posedge clk_sys_i);
		bb_frame({8'h02, 16'h0355, 32'h0}, 20);
		// an unknown instruction must not write, whatever follows it
		bb_frame({8'h12, 16'h0300, 32'h1234_5678}, 56);
		bb_frame({8'h02, 16'h0244, 8'hd4, 8'hc3, 8'hb2, 8'ha1}, 56);
		repeat (8) @(posedge clk_sys_i);
		check("abort_writes", n2_wr, 1);
		check("abort_addr", {18'h0, a2}, 32'h0244);
		check("abort_data", d2, 32'ha1b2c3d4);
		finish_test();
	end
endmodule
